//--- rtl/lss_pkg.sv
package lss_pkg;
    localparam int LANES_PER_BEAT = 16;
    localparam int SLOTS          = 2;
    localparam int BEAT_ENTRIES   = LANES_PER_BEAT * SLOTS;
    localparam int GROUP_ENTRIES  = 2 * BEAT_ENTRIES;
    localparam int WAVE_LANES     = 64;
    localparam int BANKS          = 32;
    localparam int TOTAL_BYTES    = 65536;
    localparam int WG_BYTES       = 32768;
    localparam int BANK_ROWS      = TOTAL_BYTES / (BANKS * 4);
    localparam int ADDR_W         = 16;
    localparam int WG_ADDR_W      = 15;
    localparam int BANK_LSB       = 2;
    localparam int BANK_MSB       = 6;
    localparam int ROW_LSB        = 7;
    localparam int ROW_MSB        = 15;
    localparam int MAX_SERVE      = GROUP_ENTRIES;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [3:0] BE_BYTE   = 4'h1;
    localparam logic [3:0] BE_HALF   = 4'h3;
    localparam logic [3:0] BE_WORD   = 4'hF;
    localparam logic [GROUP_ENTRIES-1:0] PEND_RST = 64'h0;
    localparam logic       READY_RST = 1'b1;
    typedef enum logic [1:0] {
        LSS_IDLE  = 2'b00,
        LSS_BEAT1 = 2'b01,
        LSS_SERVE = 2'b11
    } lss_state_t;
endpackage

//--- rtl/lss_scratchpad.sv
`timescale 1ns/1ps
// What this block does
// R1 - 64 kB per compute unit; one work-group addresses at most 32 kB.
// R2 - Storage is 32 independent banks, each one 4-byte word wide.
// R3 - Bank is chosen by byte-address bits 6 to 2.
// R4 - Both 16-lane beats of a group are checked together; entries of the two beats can conflict.
// R5 - Every bank serves one access per cycle, up to 32 per cycle.
// R6 - Same-bank accesses to different 4-byte words are served on consecutive cycles.
// R7 - Replay follows with only unserved lanes enabled until all accesses finish.
// R8 - Completion time equals the queue depth of the busiest bank.
// R9 - 64 requests on one bank (32 lanes, two slots) take one access per clock, 64 cycles.
// R10 - Reads of one identical address are broadcast, not counted as conflict.
// R11 - Requests of two consecutive issue cycles, 32 lanes, are checked together.
// R12 - Conflicts stall issue; issueReady_q stays low until every access of the group is served.
// R13 - Each lane may issue two 4-byte requests per cycle.
// R14 - Byte and halfword reads occupy a full 4-byte bank slot.
// R15 - One operation may start two loads of up to four bytes each.
// R16 - No host path; only kernel requests reach the storage.
// R17 - Contents persist until overwritten; no tagging or eviction.
// R18 - Coherence only at barriers; issuer places barriers before shared reads.
// R19 - Row from address bits above 6; bits 1 to 0 pick byte lanes.
// R20 - Group of 32 lanes issued as 16-lane beats over two cycles.
module lss_scratchpad (
    input  wire logic                                         clock,
    input  wire logic                                         rst_b,
    input  wire logic                                         issueValid,
    input  wire logic [lss_pkg::BEAT_ENTRIES-1:0]             reqValid,
    input  wire logic [lss_pkg::BEAT_ENTRIES-1:0]             reqWrite,
    input  wire logic [lss_pkg::BEAT_ENTRIES-1:0][1:0]        reqSize,
    input  wire logic [lss_pkg::BEAT_ENTRIES-1:0][15:0]       reqAddr,
    input  wire logic [lss_pkg::BEAT_ENTRIES-1:0][31:0]       reqWdata,
    input  wire logic [15:0]                                  allocBase,
    output logic                                              issueReady_q,
    output logic                                              busy_q,
    output logic                                              respValid_q,
    output logic [lss_pkg::GROUP_ENTRIES-1:0]                 respMask_q,
    output logic [lss_pkg::GROUP_ENTRIES-1:0][31:0]           respData_q,
    output logic                                              done_q
);
    import lss_pkg::*;

    lss_state_t                          state_q;
    logic [GROUP_ENTRIES-1:0]            pend_q;
    logic [GROUP_ENTRIES-1:0]            wr_q;
    logic [GROUP_ENTRIES-1:0][15:0]      addr_q;
    logic [GROUP_ENTRIES-1:0][1:0]       size_q;
    logic [GROUP_ENTRIES-1:0][3:0]       be_q;
    logic [GROUP_ENTRIES-1:0][31:0]      wdata_q;
    logic [BEAT_ENTRIES-1:0][15:0]       effAddr;
    logic [BEAT_ENTRIES-1:0][3:0]        beNew;
    logic [GROUP_ENTRIES-1:0]            bankHit [BANKS];
    logic [31:0]                         bankRd [BANKS];
    logic [GROUP_ENTRIES-1:0]            served;
    logic                                capture;
    logic                                serving;
    logic [6:0]                          serveCnt_q;

    // R16 kernel issue only
    assign capture = issueValid && issueReady_q;
    assign serving = (state_q == LSS_SERVE);

    // R1 work-group window
    always_comb
    begin
        for (int i = 0; i < BEAT_ENTRIES; i++)
        begin
            effAddr[i] = 16'(allocBase + {1'b0, reqAddr[i][WG_ADDR_W-1:0]});
            // R19 byte lanes
            if (reqSize[i] == SIZE_BYTE)
            begin
                beNew[i] = BE_BYTE << reqAddr[i][1:0];
            end
            else if (reqSize[i] == SIZE_HALF)
            begin
                beNew[i] = BE_HALF << {reqAddr[i][1], 1'b0};
            end
            else
            begin
                beNew[i] = BE_WORD;
            end
        end
    end

    // R20 two beats per group
    // R11 two-beat collection
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= LSS_IDLE;
        end
        else
        begin
            case (state_q)
                LSS_IDLE:  if (capture) state_q <= LSS_BEAT1;
                LSS_BEAT1: if (capture) state_q <= LSS_SERVE;
                LSS_SERVE: if ((pend_q & ~served) == '0) state_q <= LSS_IDLE;
                default:   state_q <= LSS_IDLE;
            endcase
        end
    end

    // R12 ready only drops while a group is served
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            issueReady_q <= READY_RST;
            busy_q       <= 1'b0;
        end
        else
        begin
            issueReady_q <= !((state_q == LSS_BEAT1 && capture) ||
                              (serving && (pend_q & ~served) != '0));
            busy_q       <= (state_q == LSS_BEAT1 && capture) ||
                            (serving && (pend_q & ~served) != '0);
        end
    end

    // R7 replay only unserved lanes
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_q <= PEND_RST;
        end
        else if (capture)
        begin
            pend_q <= {reqValid, pend_q[GROUP_ENTRIES-1:BEAT_ENTRIES]};
        end
        else if (serving)
        begin
            pend_q <= pend_q & ~served;
        end
    end

    // R15 two loads per beat
    // R13 two slots per lane per beat
    always_ff @(posedge clock)
    begin
        if (capture)
        begin
            wr_q   <= {reqWrite, wr_q[GROUP_ENTRIES-1:BEAT_ENTRIES]};
            addr_q <= {effAddr, addr_q[GROUP_ENTRIES-1:BEAT_ENTRIES]};
            size_q <= {reqSize, size_q[GROUP_ENTRIES-1:BEAT_ENTRIES]};
            be_q   <= {beNew, be_q[GROUP_ENTRIES-1:BEAT_ENTRIES]};
            for (int i = 0; i < BEAT_ENTRIES; i++)
            begin
                wdata_q[i]                <= wdata_q[i+BEAT_ENTRIES];
                wdata_q[i+BEAT_ENTRIES]   <= reqWdata[i] << {reqAddr[i][1:0], 3'b000};
            end
        end
    end

    // R2 one storage per bank
    for (genvar b = 0; b < BANKS; b++)
    begin : gBank
        logic [31:0] mem [BANK_ROWS];
        logic [5:0]  lead;
        logic        found;

        // R5 one leader per bank
        always_comb
        begin
            found = 1'b0;
            lead  = 6'h00;
            for (int e = GROUP_ENTRIES - 1; e >= 0; e--)
            begin
                // R3 bank bits
                if (pend_q[e] && addr_q[e][BANK_MSB:BANK_LSB] == 5'(b))
                begin
                    found = 1'b1;
                    lead  = 6'(e);
                end
            end
            for (int e = 0; e < GROUP_ENTRIES; e++)
            begin
                // R10 same-address read broadcast
                bankHit[b][e] = found && pend_q[e] &&
                                addr_q[e][BANK_MSB:BANK_LSB] == 5'(b) &&
                                (6'(e) == lead || (!wr_q[lead] && !wr_q[e] &&
                                addr_q[e][15:2] == addr_q[lead][15:2]));
            end
        end

        // R17 storage has no reset and no eviction
        always_ff @(posedge clock)
        begin
            // R18 write lands when served
            if (serving && found && wr_q[lead])
            begin
                for (int k = 0; k < 4; k++)
                begin
                    if (be_q[lead][k])
                    begin
                        mem[addr_q[lead][ROW_MSB:ROW_LSB]][k*8 +: 8] <= wdata_q[lead][k*8 +: 8];
                    end
                end
            end
        end

        // R19 row above bit 6
        assign bankRd[b] = mem[addr_q[lead][ROW_MSB:ROW_LSB]];
    end

    // R4 both beats arbitrated together
    always_comb
    begin
        served = '0;
        for (int b = 0; b < BANKS; b++)
        begin
            served = served | bankHit[b];
        end
        if (!serving)
        begin
            served = '0;
        end
    end

    // R14 sub-word reads take a full slot
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            respValid_q <= 1'b0;
            respMask_q  <= '0;
            respData_q  <= '0;
            done_q      <= 1'b0;
        end
        else
        begin
            respValid_q <= served != '0;
            respMask_q  <= served;
            done_q      <= serving && (pend_q & ~served) == '0;
            for (int e = 0; e < GROUP_ENTRIES; e++)
            begin
                if (served[e] && !wr_q[e])
                begin
                    respData_q[e] <= (bankRd[addr_q[e][BANK_MSB:BANK_LSB]] >>
                                      {addr_q[e][1:0], 3'b000}) &
                                     ((size_q[e] == SIZE_BYTE) ? 32'h000000FF :
                                      (size_q[e] == SIZE_HALF) ? 32'h0000FFFF :
                                      32'hFFFFFFFF);
                end
            end
        end
    end

    // R8 serve cycle count
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            serveCnt_q <= 7'h00;
        end
        else
        begin
            serveCnt_q <= serving ? 7'(serveCnt_q + 7'h01) : 7'h00;
        end
    end

    a_serve_bound: assert property ( // R9
        @(posedge clock) disable iff (!rst_b) serveCnt_q <= 7'(MAX_SERVE))
        else $error("group took more than 64 serve cycles");

    a_progress_each: assert property ( // R6
        @(posedge clock) disable iff (!rst_b)
        serving && pend_q != '0 |-> served != '0)
        else $error("pending accesses but nothing served");

    a_served_pending: assert property ( // R7
        @(posedge clock) disable iff (!rst_b) (served & ~pend_q) == '0)
        else $error("served a lane that was not pending");

    a_mask_retires: assert property ( // R7
        @(posedge clock) disable iff (!rst_b)
        respValid_q |-> ($past(pend_q) & respMask_q) == respMask_q && (pend_q & respMask_q) == '0)
        else $error("served lane still pending");

    a_done_empty: assert property ( // R8
        @(posedge clock) disable iff (!rst_b)
        done_q |-> pend_q == '0 && state_q == LSS_IDLE && issueReady_q)
        else $error("done while accesses remain");

    a_busy_ready: assert property ( // R12
        @(posedge clock) disable iff (!rst_b) busy_q == !issueReady_q)
        else $error("busy and ready disagree");

    a_collect_two: assert property ( // R11
        @(posedge clock) disable iff (!rst_b)
        state_q == LSS_IDLE && capture ##1 capture |=> serving)
        else $error("two beats did not start serving");

    a_broadcast_once: assert property ( // R10
        @(posedge clock) disable iff (!rst_b)
        serving && pend_q == 64'h3 && !wr_q[0] && !wr_q[1] &&
        addr_q[0] == addr_q[1] |-> served == 64'h3)
        else $error("same-address reads not broadcast");

    a_idle_silent: assert property ( // R5
        @(posedge clock) disable iff (!rst_b) !serving |=> !respValid_q)
        else $error("response outside serve state");

endmodule // lss_scratchpad

//--- testbench/lss_lane_model.sv
`timescale 1ns/1ps
module lss_lane_model (
    input  wire logic         clock,
    input  wire logic         issueReady_q,
    output logic              issueValid,
    output logic [31:0]       reqValid,
    output logic [31:0]       reqWrite,
    output logic [31:0][1:0]  reqSize,
    output logic [31:0][15:0] reqAddr,
    output logic [31:0][31:0] reqWdata,
    output logic [15:0]       allocBase
);
    logic        entValid [64];
    logic        entWrite [64];
    logic [1:0]  entSize  [64];
    logic [15:0] entAddr  [64];
    logic [31:0] entData  [64];
    logic [15:0] base;
    logic        hung;
    initial
    begin
        issueValid = 1'b0;
        reqValid   = '0;
        reqWrite   = '0;
        reqSize    = '0;
        reqAddr    = '0;
        reqWdata   = '0;
        allocBase  = '0;
        base       = '0;
        hung       = 1'b0;
    end
    task automatic sendGroup();
        logic rdy;
        int   k;
        k = 0;
        // 16 lanes, two slots, two beats
        for (int b = 0; b < 2; b++)
        begin
            issueValid <= 1'b1;
            allocBase  <= base;
            for (int e = 0; e < 32; e++)
            begin
                reqValid[e] <= entValid[b*32+e];
                reqWrite[e] <= entWrite[b*32+e];
                reqSize[e]  <= entSize[b*32+e];
                reqAddr[e]  <= entAddr[b*32+e];
                reqWdata[e] <= entData[b*32+e];
            end
            do
            begin
                #1;
                rdy = issueReady_q;
                @(posedge clock);
                k++;
            end while (!rdy && k < 200);
        end
        hung = (k >= 200);
        issueValid <= 1'b0;
        reqValid   <= '0;
        reqAddr    <= ~reqAddr;
        reqWdata   <= ~reqWdata;
    endtask
endmodule // lss_lane_model

//--- testbench/test_banked_scratchpad_conflict_arbiter.sv
`timescale 1ns/1ps
module test_banked_scratchpad_conflict_arbiter;
    import lss_pkg::*;
    logic              clock;
    logic              rst_b;
    logic              issueValid;
    logic [31:0]       reqValid;
    logic [31:0]       reqWrite;
    logic [31:0][1:0]  reqSize;
    logic [31:0][15:0] reqAddr;
    logic [31:0][31:0] reqWdata;
    logic [15:0]       allocBase;
    logic              issueReady_q;
    logic              busy_q;
    logic              respValid_q;
    logic [63:0]       respMask_q;
    logic [63:0][31:0] respData_q;
    logic              done_q;
    logic [63:0]       maskOr;
    logic [31:0]       got [64];
    int                failures;
    int                checks;
    int                serves;
    int                first;
    lss_scratchpad i_lss_scratchpad (.clock(clock), .rst_b(rst_b),
        .issueValid(issueValid), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqSize(reqSize), .reqAddr(reqAddr), .reqWdata(reqWdata),
        .allocBase(allocBase), .issueReady_q(issueReady_q), .busy_q(busy_q),
        .respValid_q(respValid_q), .respMask_q(respMask_q),
        .respData_q(respData_q), .done_q(done_q));
    lss_lane_model i_lss_lane_model (.clock(clock), .issueReady_q(issueReady_q),
        .issueValid(issueValid), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqSize(reqSize), .reqAddr(reqAddr), .reqWdata(reqWdata),
        .allocBase(allocBase));
    always #10 clock = ~clock;
    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic setEnt(input int e, input logic w, input logic [1:0] s,
                          input logic [15:0] a, input logic [31:0] d);
        i_lss_lane_model.entValid[e] = 1'b1;
        i_lss_lane_model.entWrite[e] = w;
        i_lss_lane_model.entSize[e]  = s;
        i_lss_lane_model.entAddr[e]  = a;
        i_lss_lane_model.entData[e]  = d;
    endtask
    task automatic clearEnt();
        for (int e = 0; e < 64; e++)
            i_lss_lane_model.entValid[e] = 1'b0;
    endtask
    task automatic runGroup(input int nexp, input logic [63:0] mexp);
        int c;
        serves = 0;
        first  = 0;
        maskOr = '0;
        @(posedge clock);
        i_lss_lane_model.sendGroup();
        #1;
        check(busy_q === 1'b1, "not busy");
        for (c = 1; c < 120; c++)
        begin
            @(posedge clock);
            #1;
            if (respValid_q === 1'b1)
            begin
                serves++;
                if (first == 0)
                    first = c;
                maskOr |= respMask_q;
                for (int e = 0; e < 64; e++)
                    if (respMask_q[e] === 1'b1)
                        got[e] = respData_q[e];
            end
            if (done_q === 1'b1)
                break;
        end
        check(done_q === 1'b1 && i_lss_lane_model.hung === 1'b0, "no done");
        if (c >= 120)
            final_report();
        check(first == 1, "latency");
        check(serves == nexp, "serve count");
        check(maskOr === mexp, "mask");
    endtask
    task automatic testConflict();
        clearEnt();
        setEnt(0, 1'b1, 2'h2, 16'h0000, 32'hCAFEF00D);
        setEnt(1, 1'b1, 2'h2, 16'h0080, 32'h12345678);
        runGroup(2, 64'h3);
        clearEnt();
        setEnt(0, 1'b0, 2'h2, 16'h0000, 32'h0);
        setEnt(1, 1'b0, SIZE_BYTE, 16'h0081, 32'h0);
        runGroup(2, 64'h3);
        check(got[0] === 32'hCAFEF00D, "word");
        check(got[1] === 32'h00000056, "byte");
        $display("test conflict done");
    endtask
    task automatic testSpread();
        clearEnt();
        for (int e = 0; e < 32; e++)
            setEnt(e, 1'b0, 2'h2, 16'(e * 4), 32'h0);
        runGroup(1, 64'hFFFFFFFF);
        check(got[0] === 32'hCAFEF00D, "bank zero");
        $display("test spread done");
    endtask
    task automatic testBcast();
        logic ok;
        ok = 1'b1;
        clearEnt();
        i_lss_lane_model.base = 16'h0080;
        for (int e = 0; e < 32; e++)
            setEnt(e, 1'b0, 2'h2, 16'h0000, 32'h0);
        runGroup(1, 64'hFFFFFFFF);
        for (int e = 0; e < 32; e++)
            ok &= (got[e] === 32'h12345678);
        check(ok, "broadcast");
        i_lss_lane_model.base = 16'h0000;
        clearEnt();
        setEnt(0, 1'b0, 2'h2, 16'h0080, 32'h0);
        setEnt(1, 1'b0, 2'h2, 16'h0080, 32'h0);
        runGroup(1, 64'h3);
        check(got[1] === 32'h12345678, "pair broadcast");
        $display("test broadcast done");
    endtask
    task automatic testBeats();
        clearEnt();
        setEnt(0, 1'b0, 2'h2, 16'h0000, 32'h0);
        setEnt(32, 1'b0, 2'h2, 16'h0080, 32'h0);
        runGroup(2, 64'h0000000100000001);
        clearEnt();
        for (int e = 0; e < 32; e++)
        begin
            setEnt(e, 1'b0, 2'h2, 16'(e * 128), 32'h0);
            setEnt(e + 32, 1'b0, 2'h2, 16'((e + 32) * 128), 32'h0);
        end
        runGroup(64, 64'hFFFFFFFFFFFFFFFF);
        $display("test beats done");
    endtask
    initial
    begin
        clock    = 1'b0;
        rst_b    = 1'b0;
        failures = 0;
        checks   = 0;
        repeat (10) @(posedge clock);
        check(issueReady_q === 1'b1 && busy_q === 1'b0 && done_q === 1'b0, "reset");
        rst_b <= 1'b1;
        testConflict();
        testSpread();
        testBcast();
        testBeats();
        final_report();
    end
endmodule // test_banked_scratchpad_conflict_arbiter
